// [accel_irq_status_and_mode_control.v]
`include "accel_regs_consts.vh"

// Operation
// - bit 5 sets on enabled transient event; clears on transient register read
// - bit 4 sets on enabled orientation change; clears on orientation status read
// - bit 3 sets on enabled tap event; clears on tap register read
// - bit 2 sets on enabled free-fall/motion interrupt; clears on its register read
// - bit 1 sets on vector-magnitude interrupt; clears on flag register read
// - bit 0 sets on new sample; clears after X, Y, Z read
// - six-byte burst from X high byte fetches all axes
// - read-only identity register at 0Dh holds fixed code
// - bits 7:6 pick sleep rate 50, 12.5, 6.25, 1.56 Hz
// - auto-sleep runs everything at the sleep rate
// - bits 5:3 pick output rate 800 down to 1.5625 Hz
// - bit 2 enables low-noise mode, range limited to 4 g
// - bit 1 fast-read: high bytes only, burst skips low bytes
// - bit 0 selects standby or active, resets to standby
// - writing 03h to temperature control halves all rates
// - flag register read clears only vector-magnitude flag
module accel_irq_status_and_mode_control (
   // clock and reset
   input wire clock,
   input wire reset,
   input wire clockEnable,
   // register access port from serial front end
   input wire regSelect,
   input wire regWrite,
   input wire burstStart,
   input wire [7:0] regAddress,
   input wire [7:0] regWriteData,
   output reg [7:0] regReadData_q,
   output reg [7:0] regAddrNext_q,
   // function engine events
   input wire transientActive,
   input wire orientationChange,
   input wire tapActive,
   input wire ffmtActive,
   input wire vecmInterrupt,
   input wire newSample,
   input wire [5:0] functionIntEnable,
   input wire autoSleeping,
   // sample data
   input wire [7:0] outXHi,
   input wire [7:0] outXLo,
   input wire [7:0] outYHi,
   input wire [7:0] outYLo,
   input wire [7:0] outZHi,
   input wire [7:0] outZLo,
   input wire [7:0] transientReg,
   input wire [7:0] orientationReg,
   input wire [7:0] tapReg,
   input wire [7:0] ffmtReg,
   input wire [7:0] transientAddr,
   input wire [7:0] orientationAddr,
   input wire [7:0] tapAddr,
   input wire [7:0] ffmtAddr,
   // control and status out
   output reg [7:0] interruptFlags_q,
   output reg activeMode_q,
   output reg lowNoise_q,
   output reg fastRead_q,
   output reg tempEnabled_q,
   output reg [`PERIOD_MS_W-1:0] samplePeriod_q
);
   // ****************************************
   // pin synchronisers for engine events
   // ****************************************
   // engine events come from another clock, so two flops stand before any use
   reg [5:0] eventMeta_q;
   reg [5:0] eventSync_q;
   reg autoSleepMeta_q;
   reg autoSleepSync_q;
   wire [5:0] eventRaw;
   assign eventRaw = {transientActive, orientationChange, tapActive, ffmtActive,
      vecmInterrupt, newSample};

   always @(posedge clock) begin
      if (reset) begin
         eventMeta_q <= `EVENT_NONE;
         eventSync_q <= `EVENT_NONE;
         autoSleepMeta_q <= 1'b0;
         autoSleepSync_q <= 1'b0;
      end else if (clockEnable) begin
         eventMeta_q <= eventRaw;
         eventSync_q <= eventMeta_q;
         autoSleepMeta_q <= autoSleeping;
         autoSleepSync_q <= autoSleepMeta_q;
      end
   end

   // ****************************************
   // control registers
   // ****************************************
   reg [7:0] systemControl_q;
   reg [7:0] temperatureControl_q;
   wire readStrobe;
   wire writeStrobe;
   assign readStrobe = regSelect & ~regWrite;
   assign writeStrobe = regSelect & regWrite;

   // one read access of the given address
   function readHit;
      input strobe;
      input [7:0] addr;
      input [7:0] target;
      begin
         readHit = strobe & (addr == target);
      end
   endfunction

   always @(posedge clock) begin
      if (reset) begin
         systemControl_q <= `CTRL_RESET;
         temperatureControl_q <= `TEMP_RESET;
      end else if (clockEnable && writeStrobe) begin
         // host keeps fields stable while active
         if (regAddress == `ADDR_SYS_CTRL) begin
            systemControl_q <= regWriteData;
         end
         if (regAddress == `ADDR_TEMP_CTRL) begin
            temperatureControl_q <= regWriteData;
         end
      end
   end

   // ****************************************
   // rate selection
   // ****************************************
   wire [`PERIOD_MS_W-1:0] periodNow;
   rate_decode rateDecode (
      .outputRateSelect(systemControl_q[`CTRL_RATE_HI:`CTRL_RATE_LO]),
      .sleepRateSelect(systemControl_q[`CTRL_SLEEP_HI:`CTRL_SLEEP_LO]),
      .tempEnable(temperatureControl_q == `TEMP_ENABLE_CODE),
      .sleeping(autoSleepSync_q),
      .periodQuarterMs(periodNow)
   );

   always @(posedge clock) begin
      if (reset) begin
         activeMode_q <= 1'b0;
         lowNoise_q <= 1'b0;
         fastRead_q <= 1'b0;
         tempEnabled_q <= 1'b0;
         samplePeriod_q <= {`PERIOD_MS_W{1'b0}};
      end else if (clockEnable) begin
         activeMode_q <= systemControl_q[`CTRL_ACTIVE];
         lowNoise_q <= systemControl_q[`CTRL_LNOISE];
         // fifo mode gating is host duty
         fastRead_q <= systemControl_q[`CTRL_FREAD];
         tempEnabled_q <= (temperatureControl_q == `TEMP_ENABLE_CODE);
         samplePeriod_q <= periodNow;
      end
   end

   // ****************************************
   // axis read tracking for data-ready
   // ****************************************
   reg [2:0] axisRead_q;
   wire [2:0] axisHit;
   // fast-read ends each axis at its high byte, else at its low byte
   assign axisHit[0] = readStrobe & (regAddress == (fastRead_q ? `ADDR_OUT_X_HI : `ADDR_OUT_X_LO));
   assign axisHit[1] = readStrobe & (regAddress == (fastRead_q ? `ADDR_OUT_Y_HI : `ADDR_OUT_Y_LO));
   assign axisHit[2] = readStrobe & (regAddress == (fastRead_q ? `ADDR_OUT_Z_HI : `ADDR_OUT_Z_LO));
   wire allAxesRead;
   assign allAxesRead = ((axisRead_q | axisHit) == `AXIS_ALL);

   always @(posedge clock) begin
      if (reset) begin
         axisRead_q <= `AXIS_NONE;
      end else if (clockEnable) begin
         // new sample restarts tracking so stale reads do not clear it
         if (eventSync_q[`FLAG_DRDY] | allAxesRead) begin
            axisRead_q <= `AXIS_NONE;
         end else begin
            axisRead_q <= axisRead_q | axisHit;
         end
      end
   end

   // ****************************************
   // interrupt source flags
   // ****************************************
   wire [5:0] setFlag;
   wire [5:0] clearFlag;
   wire [5:0] flagState;
   assign setFlag = eventSync_q & {functionIntEnable[5:2], 1'b1, 1'b1};
   assign clearFlag[`FLAG_TRANS] = readHit(readStrobe, regAddress, transientAddr);
   assign clearFlag[`FLAG_ORIENT] = readHit(readStrobe, regAddress, orientationAddr);
   assign clearFlag[`FLAG_TAP] = readHit(readStrobe, regAddress, tapAddr);
   assign clearFlag[`FLAG_FFMT] = readHit(readStrobe, regAddress, ffmtAddr);
   assign clearFlag[`FLAG_VECM] = readHit(readStrobe, regAddress, `ADDR_INT_FLAGS);
   assign clearFlag[`FLAG_DRDY] = allAxesRead;

   genvar i;
   generate
      for (i = 0; i < 6; i = i + 1) begin : flags
         flag_bit flagBit (
            .clock(clock),
            .reset(reset),
            .clockEnable(clockEnable),
            .setEvent(setFlag[i]),
            .clearEvent(clearFlag[i]),
            .flag_q(flagState[i])
         );
      end
   endgenerate

   always @(posedge clock) begin
      if (reset) begin
         interruptFlags_q <= `BYTE_ZERO;
      end else if (clockEnable) begin
         interruptFlags_q <= {2'b00, flagState};
      end
   end

   // ****************************************
   // read data and burst address pointer
   // ****************************************
   function [7:0] nextAddr;
      input [7:0] addr;
      input fast;
      begin
         if (fast && (addr == `ADDR_OUT_X_HI || addr == `ADDR_OUT_Y_HI)) begin
            nextAddr = addr + `ADDR_SKIP;
         end else if (fast && addr == `ADDR_OUT_Z_HI) begin
            nextAddr = addr + `ADDR_SKIP;
         end else begin
            nextAddr = addr + `ADDR_STEP;
         end
      end
   endfunction

   reg [7:0] readMux;
   always @* begin
      case (regAddress)
         `ADDR_OUT_X_HI: readMux = outXHi;
         `ADDR_OUT_X_LO: readMux = outXLo;
         `ADDR_OUT_Y_HI: readMux = outYHi;
         `ADDR_OUT_Y_LO: readMux = outYLo;
         `ADDR_OUT_Z_HI: readMux = outZHi;
         `ADDR_OUT_Z_LO: readMux = outZLo;
         `ADDR_INT_FLAGS: readMux = {2'b00, flagState};
         `ADDR_IDENTITY: readMux = `IDENTITY_CODE;
         `ADDR_SYS_CTRL: readMux = systemControl_q;
         `ADDR_TEMP_CTRL: readMux = temperatureControl_q;
         default: readMux = `BYTE_ZERO;
      endcase
      if (regAddress == transientAddr) begin
         readMux = transientReg;
      end
      if (regAddress == orientationAddr) begin
         readMux = orientationReg;
      end
      if (regAddress == tapAddr) begin
         readMux = tapReg;
      end
      if (regAddress == ffmtAddr) begin
         readMux = ffmtReg;
      end
   end

   always @(posedge clock) begin
      if (reset) begin
         regReadData_q <= `BYTE_ZERO;
      end else if (clockEnable && readStrobe) begin
         regReadData_q <= readMux;
      end
   end

   // ****************************************
   // burst address pointer
   // ****************************************
   // later bytes step from the pointer, not from whatever address the host still shows
   wire [7:0] burstBase;
   assign burstBase = burstStart ? regAddress : regAddrNext_q;

   always @(posedge clock) begin
      if (reset) begin
         regAddrNext_q <= `BYTE_ZERO;
      end else if (clockEnable && regSelect) begin
         regAddrNext_q <= nextAddr(burstBase, fastRead_q);
      end
   end
endmodule

// [accel_regs_consts.vh]
`ifndef ACCEL_REGS_CONSTS_VH
`define ACCEL_REGS_CONSTS_VH

// ****************************************
// register addresses
// ****************************************
`define ADDR_OUT_X_HI 8'h01
`define ADDR_OUT_X_LO 8'h02
`define ADDR_OUT_Y_HI 8'h03
`define ADDR_OUT_Y_LO 8'h04
`define ADDR_OUT_Z_HI 8'h05
`define ADDR_OUT_Z_LO 8'h06
`define ADDR_INT_FLAGS 8'h0C
`define ADDR_IDENTITY 8'h0D
`define ADDR_TEMP_CTRL 8'h1E
`define ADDR_SYS_CTRL 8'h2A

// ****************************************
// interrupt source flag positions
// ****************************************
`define FLAG_TRANS 5
`define FLAG_ORIENT 4
`define FLAG_TAP 3
`define FLAG_FFMT 2
`define FLAG_VECM 1
`define FLAG_DRDY 0

// ****************************************
// system control fields
// ****************************************
`define CTRL_SLEEP_HI 7
`define CTRL_SLEEP_LO 6
`define CTRL_RATE_HI 5
`define CTRL_RATE_LO 3
`define CTRL_LNOISE 2
`define CTRL_FREAD 1
`define CTRL_ACTIVE 0
`define CTRL_RESET 8'h00

// ****************************************
// misc values
// ****************************************
`define TEMP_ENABLE_CODE 8'h03
`define TEMP_RESET 8'h00
`define BYTE_ZERO 8'h00
// arbitrary value, not any maker's code
`define IDENTITY_CODE 8'h5C
`define EVENT_NONE 6'h00
`define ADDR_STEP 8'h01
`define ADDR_SKIP 8'h02
`define AXIS_ALL 3'h7
`define AXIS_NONE 3'h0

// ****************************************
// sample periods in quarter-ms units
// ****************************************
`define PERIOD_MS_W 13
`define PERIOD_1MS25 13'h0005
`define PERIOD_2MS5 13'h000A
`define PERIOD_5MS 13'h0014
`define PERIOD_10MS 13'h0028
`define PERIOD_20MS 13'h0050
`define PERIOD_80MS 13'h0140
`define PERIOD_160MS 13'h0280
`define PERIOD_640MS 13'h0A00

`endif

// [rate_decode.v]
`include "accel_regs_consts.vh"

module rate_decode (
   // control fields
   input wire [2:0] outputRateSelect,
   input wire [1:0] sleepRateSelect,
   input wire tempEnable,
   input wire sleeping,
   // sample period in ms (x4 for fraction)
   output wire [`PERIOD_MS_W-1:0] periodQuarterMs
);
   // ****************************************
   // rate tables
   // ****************************************
   // quarter-ms units keep 1.25 ms exact
   function [`PERIOD_MS_W-1:0] outPeriod;
      input [2:0] sel;
      begin
         case (sel)
            3'h0: outPeriod = `PERIOD_1MS25;
            3'h1: outPeriod = `PERIOD_2MS5;
            3'h2: outPeriod = `PERIOD_5MS;
            3'h3: outPeriod = `PERIOD_10MS;
            3'h4: outPeriod = `PERIOD_20MS;
            3'h5: outPeriod = `PERIOD_80MS;
            3'h6: outPeriod = `PERIOD_160MS;
            default: outPeriod = `PERIOD_640MS;
         endcase
      end
   endfunction

   // sleep rates 50, 12.5, 6.25, 1.56 Hz
   function [`PERIOD_MS_W-1:0] sleepPeriod;
      input [1:0] sel;
      begin
         case (sel)
            2'h0: sleepPeriod = `PERIOD_20MS;
            2'h1: sleepPeriod = `PERIOD_80MS;
            2'h2: sleepPeriod = `PERIOD_160MS;
            default: sleepPeriod = `PERIOD_640MS;
         endcase
      end
   endfunction

   wire [`PERIOD_MS_W-1:0] basePeriod;
   assign basePeriod = sleeping ? sleepPeriod(sleepRateSelect) : outPeriod(outputRateSelect);
   assign periodQuarterMs = tempEnable ? {basePeriod[`PERIOD_MS_W-2:0], 1'b0} : basePeriod;
endmodule

// [flag_bit.v]
module flag_bit (
   // clock and control
   input wire clock,
   input wire reset,
   input wire clockEnable,
   // set and clear
   input wire setEvent,
   input wire clearEvent,
   // state
   output reg flag_q
);
   always @(posedge clock) begin
      if (reset) begin
         flag_q <= 1'b0;
      end else if (clockEnable) begin
         if (setEvent) begin
            flag_q <= 1'b1;
         end else if (clearEvent) begin
            flag_q <= 1'b0;
         end
      end
   end
endmodule

// [accel_irq_status_and_mode_control_assertions.sv]
`include "accel_regs_consts.vh"

module accel_irq_status_and_mode_control_checker (
   // watched ports
   input wire clock,
   input wire reset,
   input wire clockEnable,
   input wire regSelect,
   input wire regWrite,
   input wire burstStart,
   input wire [7:0] regAddress,
   input wire [7:0] regWriteData,
   input wire [7:0] regReadData_q,
   input wire [7:0] regAddrNext_q,
   input wire vecmInterrupt,
   input wire [7:0] transientAddr,
   input wire [7:0] tapAddr,
   input wire [7:0] interruptFlags_q,
   input wire activeMode_q,
   input wire lowNoise_q,
   input wire fastRead_q,
   input wire tempEnabled_q
);
   timeunit 1ns;
   timeprecision 1ps;
   wire rd = clockEnable && regSelect && !regWrite;
   wire wr = clockEnable && regSelect && regWrite;
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   chk_reset_standby: assert property ($fell(reset) |-> !activeMode_q && !interruptFlags_q)
      else $error("state not cleared by reset");
   chk_identity_read: assert property (rd && regAddress == 8'h0D |-> ##[1:2] regReadData_q == `IDENTITY_CODE)
      else $error("identity read wrong");
   // the engine input is quiet long enough that no set can race the clear
   chk_vecm_clear: assert property ((!vecmInterrupt)[*5] ##0 (rd && regAddress == 8'h0C) |-> ##2 !interruptFlags_q[1])
      else $error("vector flag not cleared");
   chk_trans_hold: assert property ($fell(interruptFlags_q[5]) && !$past(reset) |-> $past(rd && regAddress == transientAddr, 2))
      else $error("transient flag fell without its read");
   chk_tap_hold: assert property ($fell(interruptFlags_q[3]) && !$past(reset) |-> $past(rd && regAddress == tapAddr, 2))
      else $error("tap flag fell without its read");
   chk_ctrl_write: assert property (wr && regAddress == 8'h2A |-> ##2 {lowNoise_q, fastRead_q, activeMode_q} == $past(regWriteData[2:0], 2))
      else $error("control bits not taken");
   chk_temp_write: assert property (wr && regAddress == 8'h1E |-> ##2 tempEnabled_q == ($past(regWriteData, 2) == 8'h03))
      else $error("temperature enable wrong");
   chk_burst_norm: assert property (rd && burstStart && regAddress == 8'h01 && !fastRead_q |-> ##[1:2] regAddrNext_q == 8'h02)
      else $error("burst does not step to low byte");
   chk_burst_fast: assert property (rd && burstStart && regAddress == 8'h01 && fastRead_q |-> ##[1:2] regAddrNext_q == 8'h03)
      else $error("fast burst does not skip low byte");
endmodule

bind accel_irq_status_and_mode_control accel_irq_status_and_mode_control_checker i_checker (.*);

// [host_model.sv]
module host_model (
   // clock and answer
   input wire clock,
   input wire [7:0] regReadData_q,
   // request
   output logic regSelect = 1'b0,
   output logic regWrite = 1'b0,
   output logic burstStart = 1'b0,
   output logic [7:0] regAddress = 8'h00,
   output logic [7:0] regWriteData = 8'h00
);
   timeunit 1ns;
   timeprecision 1ps;
   // host opens burst at first byte
   task automatic acc(input logic w, input logic b, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] q);
      @(posedge clock);
      #1;
      regSelect = 1'b1;
      regWrite = w;
      burstStart = b;
      regAddress = a;
      regWriteData = d;
      @(posedge clock);
      #1;
      regSelect = 1'b0;
      burstStart = 1'b0;
      // released lines flip so a stale value is never mistaken for a hold
      regAddress = ~a;
      regWriteData = ~d;
      @(posedge clock);
      #1;
      q = regReadData_q;
   endtask
endmodule

// [accel_irq_status_and_mode_control_tb.sv]
`include "accel_regs_consts.vh"

module accel_irq_status_and_mode_control_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic reset = 1'b1;
   logic autoSleeping = 1'b0;
   logic clockEnable = 1'b1;
   logic [5:0] ev = 6'h00;
   logic [5:0] functionIntEnable = 6'h00;
   logic [7:0] samp [6] = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55, 8'h66};
   logic [7:0] srcAddr [6] = '{8'h00, 8'h0C, 8'h16, 8'h22, 8'h10, 8'h1D};
   logic [7:0] q, ctl = 8'h00;
   logic regSelect, regWrite, burstStart, activeMode_q, lowNoise_q, fastRead_q, tempEnabled_q;
   logic [7:0] regAddress, regWriteData, regReadData_q, regAddrNext_q, interruptFlags_q;
   logic [12:0] samplePeriod_q;
   int err_count = 0;
   int samples_checked = 0;
   int odr [8] = '{5, 10, 20, 40, 80, 320, 640, 2560};
   int slp [4] = '{80, 320, 640, 2560};

   accel_irq_status_and_mode_control i_accel_irq_status_and_mode_control (
      .transientActive(ev[5]), .orientationChange(ev[4]), .tapActive(ev[3]), .ffmtActive(ev[2]),
      .vecmInterrupt(ev[1]), .newSample(ev[0]), .outXHi(samp[0]), .outXLo(samp[1]),
      .outYHi(samp[2]), .outYLo(samp[3]), .outZHi(samp[4]), .outZLo(samp[5]),
      .transientReg(8'hA5), .orientationReg(8'h5A), .tapReg(8'hC3), .ffmtReg(8'h3C),
      .transientAddr(srcAddr[5]), .orientationAddr(srcAddr[4]), .tapAddr(srcAddr[3]),
      .ffmtAddr(srcAddr[2]), .*);
   host_model i_host_model (.*);

   // ****************************************
   // helpers
   // ****************************************
   task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
      samples_checked++;
      if (s !== e) begin
         err_count++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic rd(input logic [7:0] a);
      i_host_model.acc(1'b0, 1'b0, a, 8'h00, q);
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      i_host_model.acc(1'b1, 1'b0, a, d, q);
   endtask
   task automatic pulse(input int i);
      ev[i] = 1'b1;
      cyc(1);
      ev[i] = 1'b0;
      cyc(6);
   endtask
   task automatic cfg(input logic [7:0] v);
      wr(`ADDR_SYS_CTRL, ctl & 8'hFE);
      wr(`ADDR_SYS_CTRL, v & 8'hFE);
      wr(`ADDR_SYS_CTRL, v);
      ctl = v;
      cyc(4);
   endtask

   // ****************************************
   // scenarios
   // ****************************************
   task automatic t_basic;
      chk("flags", interruptFlags_q, 8'h00);
      chk("active", activeMode_q, 1'b0);
      wr(`ADDR_IDENTITY, 8'hFF);
      rd(`ADDR_IDENTITY);
      chk("ident", q, `IDENTITY_CODE);
   endtask
   task automatic t_flags;
      for (int i = 5; i >= 2; i--) begin
         functionIntEnable = 6'h00;
         pulse(i);
         chk("flag off", interruptFlags_q[i], 1'b0);
         functionIntEnable = 6'h3C;
         pulse(i);
         chk("flag set", interruptFlags_q[i], 1'b1);
         rd(`ADDR_INT_FLAGS);
         chk("flag rd", q[i], 1'b1);
         cyc(2);
         chk("flag kept", interruptFlags_q[i], 1'b1);
         rd(srcAddr[i]);
         cyc(2);
         chk("flag clr", interruptFlags_q[i], 1'b0);
      end
   endtask
   task automatic t_vecm;
      pulse(1);
      rd(`ADDR_INT_FLAGS);
      chk("vecm rd", q[1], 1'b1);
      cyc(2);
      chk("vecm clr", interruptFlags_q[1], 1'b0);
   endtask
   // no FIFO here, so fast-read may always change
   task automatic t_drdy(input logic f);
      logic [7:0] a;
      a = 8'h01;
      pulse(0);
      chk("drdy set", interruptFlags_q[0], 1'b1);
      for (int k = 0; k < 6; k += 1 + f) begin
         i_host_model.acc(1'b0, k == 0, a, 8'h00, q);
         chk("burst", q, samp[k]);
         a = regAddrNext_q;
         if (k < 4) chk("next", a, 8'h02 + k + f);
      end
      cyc(2);
      chk("drdy clr", interruptFlags_q[0], 1'b0);
   endtask
   // every rate in both temperature settings, awake and asleep
   task automatic t_rates;
      for (int t = 0; t < 2; t++) begin
         wr(`ADDR_TEMP_CTRL, t ? `TEMP_ENABLE_CODE : 8'h00);
         cyc(3);
         chk("temp", tempEnabled_q, t);
         for (int d = 0; d < 8; d++) begin
            cfg({2'h0, d[2:0], d[0], 2'h1});
            chk("odr", samplePeriod_q, odr[d] << t);
            chk("lnoise", lowNoise_q, d[0]);
            chk("active", activeMode_q, 1'b1);
         end
         autoSleeping = 1'b1;
         for (int s = 0; s < 4; s++) begin
            cfg({s[1:0], 6'h01});
            chk("sleep", samplePeriod_q, slp[s] << t);
         end
         autoSleeping = 1'b0;
      end
   endtask

   // a low clock enable freezes everything; a mid-run reset returns to standby
   task automatic t_hold;
      clockEnable = 1'b0;
      wr(`ADDR_SYS_CTRL, ctl & 8'hFE);
      pulse(4);
      chk("frozen active", activeMode_q, 1'b1);
      chk("frozen flag", interruptFlags_q[4], 1'b0);
      clockEnable = 1'b1;
      pulse(4);
      chk("orient set", interruptFlags_q[4], 1'b1);
      reset = 1'b1;
      cyc(2);
      reset = 1'b0;
      chk("rst flags", interruptFlags_q, 8'h00);
      chk("rst active", activeMode_q, 1'b0);
      chk("rst temp", tempEnabled_q, 1'b0);
      chk("rst period", samplePeriod_q, 13'h0000);
      ctl = 8'h00;
   endtask

   task automatic final_report;
      $display("checks %0d errors %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   initial begin
      forever #4 clock = ~clock;
   end
   initial begin
      cyc(4);
      reset = 1'b0;
      t_basic();
      t_flags();
      t_vecm();
      t_drdy(1'b0);
      cfg(8'h03);
      chk("fread", fastRead_q, 1'b1);
      t_drdy(1'b1);
      t_rates();
      t_hold();
      final_report();
   end
   initial begin
      #100000;
      err_count++;
      final_report();
   end
endmodule
